// >>> design/se_pkg.sv
// Shared constants, types and helpers of the serial EEPROM client.
// Assumes a single system clock that oversamples the two-wire bus pins.
package se_pkg;
  localparam int SE_ADDR_W = 17;
  localparam int SE_HALF_W = 16;
  localparam int SE_PAGE_W = 7;
  localparam int SE_PAGE_BYTES = 128;
  localparam int SE_ROW_W = SE_ADDR_W - SE_PAGE_W;
  localparam int SE_FIFO_DEPTH = 8;
  localparam int SE_PROG_CYC = 1000;

  // Control byte layout.
  localparam logic [3:0] SE_TYPE_CODE = 4'ha;
  localparam int SE_CB_HALF = 3;
  localparam int SE_CB_RW = 0;

  // Bit counter marks within one nine-clock byte slot.
  localparam logic [3:0] SE_BIT_ACK = 4'h8;
  localparam logic [3:0] SE_BIT_LAST = 4'h9;

  // Pin vector order is {chip_select_lo, chip_select_hi, write_protect, sda, scl}.
  localparam logic [4:0] SE_PIN_IDLE = 5'h03;
  localparam int SE_PIN_SCL = 0;
  localparam int SE_PIN_SDA = 1;
  localparam int SE_PIN_WP = 2;
  localparam int SE_PIN_CSHI = 3;
  localparam int SE_PIN_CSLO = 4;

  typedef enum logic [2:0] {
    S_IDLE, S_CTRL, S_ADRH, S_ADRL, S_WDATA, S_RDATA, S_WAIT
  } se_state_t;

  // Sequential addressing stays inside the current half of the array.
  function automatic logic [SE_ADDR_W-1:0] se_inc_half(input logic [SE_ADDR_W-1:0] a);
    return {a[SE_ADDR_W-1], a[SE_HALF_W-1:0] + 16'h0001};
  endfunction
endpackage

// >>> design/se_strm_if.sv
// Valid/ready byte stream between the EEPROM core and its read FIFO.
// Assumes both ends run on clk_sys.
interface se_strm_if #(parameter int W = 8);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport source (output valid, output data, input ready);
  modport sink (input valid, input data, output ready);
endinterface

// >>> design/se_fifo.sv
// Synchronous FIFO with flush, valid/ready on both sides.
// Assumes flush and traffic come from logic on clk_sys.
module se_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic flush,
  se_strm_if.sink in_s,
  se_strm_if.source out_s
);
  import se_pkg::*;
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] store [DEPTH];
  logic [AW-1:0] wr_idx;
  logic [AW-1:0] rd_idx;
  logic [AW:0] level;
  logic push;
  logic pop;

  assign in_s.ready = (level != (AW+1)'(DEPTH));
  assign out_s.valid = (level != '0);
  assign out_s.data = store[rd_idx];
  assign push = in_s.valid && in_s.ready;
  assign pop = out_s.valid && out_s.ready;

  function automatic logic [AW-1:0] next_idx(input logic [AW-1:0] i);
    return (i == AW'(DEPTH - 1)) ? '0 : i + 1'b1;
  endfunction

  always_ff @(posedge clk_sys) begin
    if (push && !flush) begin
      store[wr_idx] <= in_s.data;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      wr_idx <= '0;
      rd_idx <= '0;
      level <= '0;
    end else if (flush) begin
      wr_idx <= '0;
      rd_idx <= '0;
      level <= '0;
    end else begin
      if (push) begin
        wr_idx <= next_idx(wr_idx);
      end
      if (pop) begin
        rd_idx <= next_idx(rd_idx);
      end
      level <= level + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// >>> design/se_eeprom.sv
// Two-wire serial EEPROM client: page writes, write protect, polling and reads.
// Assumes an external host drives scl and frames; pins are asynchronous to clk_sys.
// Operation
// - Each written byte steps only the low seven pointer bits; upper ten stay.
// - More than 128 bytes wrap the in-page pointer and overwrite earlier bytes.
// - Programming starts only on the Stop that ends a write command.
// - With write protect high, writes are acknowledged but nothing is stored.
// - Page data past the page end wraps to the page start.
// - Pages start at multiples of the page size and end just before the next.
// - Write protect covers the whole array; releasing it re-enables writes.
// - Write protect is sampled at Stop; later changes do not affect the cycle.
// - A matching polling control byte is not acknowledged while programming.
// - A read command is a control byte with the direction bit set.
// - Current-address read acknowledges and returns the byte after the last one.
// - Host ends a read with no acknowledge and Stop; the device stops driving.
// - Address bytes then repeated Start load the pointer without programming.
// - After a random read the pointer holds the next address.
// - Each host acknowledge in a read fetches the byte at the next address.
// - Acknowledge of the last lower-half byte wraps to the lower-half start.
// - Acknowledge of the last upper-half byte wraps to the upper-half start.
// - Control byte is type code, half select, two chip selects, direction.
// - Respond only when chip-select bits equal the strapped inputs.
// - Address bytes arrive upper byte first, then lower byte.
// - On a missing read acknowledge the data line is released high.
module se_eeprom #(
  parameter int PROG_CYC = se_pkg::SE_PROG_CYC,
  parameter int FIFO_DEPTH = se_pkg::SE_FIFO_DEPTH
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic write_protect,
  input wire logic chip_select_hi,
  input wire logic chip_select_lo,
  output logic prog_busy,
  output logic [se_pkg::SE_ADDR_W-1:0] addr_ptr
);
  import se_pkg::*;
  localparam int CNT_W = $clog2(PROG_CYC + 1);

  logic [4:0] sy0;
  logic [4:0] sy1;
  logic [4:0] sy2;
  logic [4:0] pin;
  logic [4:0] pin_d;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic flush;

  se_state_t st;
  logic [3:0] bitcnt;
  logic [7:0] rx;
  logic [7:0] tx;
  logic [7:0] ctrl_w;
  logic [SE_ADDR_W-1:0] ptr;
  logic [SE_PAGE_BYTES-1:0] mask;
  logic [7:0] pbuf [SE_PAGE_BYTES];
  logic [7:0] mem [2**SE_ADDR_W];
  logic got_data;
  logic active;
  logic byte_done;
  logic addr_hit;
  logic poll_block;
  logic [7:0] rd_byte;

  logic busy;
  logic [CNT_W-1:0] cnt;
  logic [SE_ROW_W-1:0] row;
  logic commit;
  logic [SE_ADDR_W-1:0] pf_addr;

  se_strm_if #(.W(8)) pf ();
  se_strm_if #(.W(8)) rd ();

  assign sda_out = 1'b0;
  assign prog_busy = busy;
  assign addr_ptr = ptr;

  // The first stage feeds only the second; a level counts once stages two and three agree.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      sy0 <= SE_PIN_IDLE;
      sy1 <= SE_PIN_IDLE;
      sy2 <= SE_PIN_IDLE;
      pin <= SE_PIN_IDLE;
      pin_d <= SE_PIN_IDLE;
    end else begin
      sy0 <= {chip_select_lo, chip_select_hi, write_protect, sda_in, scl_in};
      sy1 <= sy0;
      sy2 <= sy1;
      pin <= (sy1 & sy2) | (pin & (sy1 ^ sy2));
      pin_d <= pin;
    end
  end

  assign scl_rise = pin[SE_PIN_SCL] && !pin_d[SE_PIN_SCL];
  assign scl_fall = !pin[SE_PIN_SCL] && pin_d[SE_PIN_SCL];
  assign start_det = pin[SE_PIN_SCL] && pin_d[SE_PIN_SCL] && pin_d[SE_PIN_SDA]
                     && !pin[SE_PIN_SDA];
  assign stop_det = pin[SE_PIN_SCL] && pin_d[SE_PIN_SCL] && !pin_d[SE_PIN_SDA]
                    && pin[SE_PIN_SDA];
  assign flush = start_det || stop_det;

  assign active = (st != S_IDLE) && (st != S_WAIT);
  assign byte_done = scl_fall && (bitcnt == SE_BIT_ACK);
  assign addr_hit = (rx[7:4] == SE_TYPE_CODE)
                    && (rx[2:1] == {pin[SE_PIN_CSHI], pin[SE_PIN_CSLO]});
  // While programming, a repeat of the initiating byte and any write are refused.
  assign poll_block = busy && ((rx == ctrl_w) || !rx[SE_CB_RW]);
  assign rd.ready = scl_fall && (bitcnt == SE_BIT_LAST) && (st == S_RDATA);
  // An empty FIFO sends all ones, which leaves the line released.
  assign rd_byte = rd.valid ? rd.data : 8'hff;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st <= S_IDLE;
      bitcnt <= 4'h0;
      rx <= 8'h00;
      tx <= 8'hff;
      sda_oe_n <= 1'b1;
      ptr <= '0;
      mask <= '0;
      got_data <= 1'b0;
      ctrl_w <= 8'h00;
    end else if (start_det) begin
      // A repeated Start ends a write without programming.
      st <= S_CTRL;
      bitcnt <= 4'h0;
      sda_oe_n <= 1'b1;
    end else if (stop_det) begin
      st <= S_IDLE;
      bitcnt <= 4'h0;
      sda_oe_n <= 1'b1;
    end else if (scl_rise && active) begin
      bitcnt <= bitcnt + 4'h1;
      if (bitcnt < SE_BIT_ACK) begin
        rx <= {rx[6:0], pin[SE_PIN_SDA]};
      end else if (st == S_RDATA && pin[SE_PIN_SDA]) begin
        st <= S_WAIT;
      end
    end else if (scl_fall && active) begin
      if (bitcnt == SE_BIT_ACK) begin
        sda_oe_n <= 1'b0;
        unique case (st)
          S_CTRL: begin
            if (addr_hit && !poll_block) begin
              if (rx[SE_CB_RW]) begin
                st <= S_RDATA;
              end else begin
                st <= S_ADRH;
                ptr[SE_ADDR_W-1] <= rx[SE_CB_HALF];
                ctrl_w <= rx;
                mask <= '0;
                got_data <= 1'b0;
              end
            end else begin
              st <= S_WAIT;
              sda_oe_n <= 1'b1;
            end
          end
          S_ADRH: begin
            ptr[SE_HALF_W-1:8] <= rx;
            st <= S_ADRL;
          end
          S_ADRL: begin
            ptr[7:0] <= rx;
            st <= S_WDATA;
          end
          S_WDATA: begin
            mask[ptr[SE_PAGE_W-1:0]] <= 1'b1;
            ptr[SE_PAGE_W-1:0] <= ptr[SE_PAGE_W-1:0] + 7'h01;
            got_data <= 1'b1;
          end
          S_RDATA: sda_oe_n <= 1'b1;
          S_IDLE, S_WAIT: sda_oe_n <= 1'b1;
        endcase
      end else if (bitcnt == SE_BIT_LAST) begin
        bitcnt <= 4'h0;
        if (st == S_RDATA) begin
          sda_oe_n <= rd_byte[7];
          tx <= {rd_byte[6:0], 1'b1};
          ptr <= se_inc_half(ptr);
        end else begin
          sda_oe_n <= 1'b1;
        end
      end else if (st == S_RDATA) begin
        sda_oe_n <= tx[7];
        tx <= {tx[6:0], 1'b1};
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (byte_done && st == S_WDATA) begin
      pbuf[ptr[SE_PAGE_W-1:0]] <= rx;
    end
  end

  // Write protect is looked at only here, at the closing Stop.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      busy <= 1'b0;
      cnt <= '0;
      row <= '0;
    end else if (stop_det && st == S_WDATA && got_data && !pin[SE_PIN_WP]) begin
      busy <= 1'b1;
      cnt <= CNT_W'(PROG_CYC - 1);
      row <= ptr[SE_ADDR_W-1:SE_PAGE_W];
    end else if (busy) begin
      if (cnt == '0) begin
        busy <= 1'b0;
      end else begin
        cnt <= cnt - 1'b1;
      end
    end
  end

  assign commit = busy && (cnt == '0);

  // Only bytes received in this command are stored; the rest of the page is kept.
  always_ff @(posedge clk_sys) begin
    if (commit) begin
      for (int i = 0; i < SE_PAGE_BYTES; i++) begin
        if (mask[i]) begin
          mem[{row, SE_PAGE_W'(i)}] <= pbuf[i];
        end
      end
    end
  end

  // Prefetch runs ahead of the consumed pointer; bytes beyond a NACK are flushed.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pf_addr <= '0;
    end else if (flush) begin
      pf_addr <= ptr;
    end else if (pf.valid && pf.ready) begin
      pf_addr <= se_inc_half(pf_addr);
    end
  end

  assign pf.valid = (st == S_RDATA) && !flush;
  assign pf.data = mem[pf_addr];

  se_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .flush(flush),
    .in_s(pf),
    .out_s(rd)
  );

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence wr_stop;
    stop_det && st == S_WDATA && got_data;
  endsequence

  sequence host_nack;
    scl_rise && st == S_RDATA && bitcnt == SE_BIT_ACK && pin[SE_PIN_SDA];
  endsequence

  a_prog_start: assert property (wr_stop ##0 !pin[SE_PIN_WP] |=> busy ##1 busy)
    else $error("programming did not start at write stop");
  a_wp_skip: assert property (wr_stop ##0 pin[SE_PIN_WP] |=> !busy && st == S_IDLE)
    else $error("protected write started programming");
  a_busy_cause: assert property ($rose(busy) |-> $past(stop_det) && $past(st) == S_WDATA)
    else $error("busy rose without a write stop");
  a_busy_hold: assert property (busy && cnt != '0 |=> busy)
    else $error("programming ended early");
  a_poll_refuse: assert property (byte_done && st == S_CTRL && busy && rx == ctrl_w
                                  |=> sda_oe_n && st == S_WAIT)
    else $error("polling byte acknowledged while busy");
  a_page_step: assert property (byte_done && st == S_WDATA
                                |=> ptr[SE_ADDR_W-1:SE_PAGE_W] == $past(ptr[SE_ADDR_W-1:SE_PAGE_W])
                                && ptr[SE_PAGE_W-1:0] == $past(ptr[SE_PAGE_W-1:0]) + 7'h01)
    else $error("page pointer stepped wrongly");
  a_read_step: assert property (rd.ready |=> ptr == se_inc_half($past(ptr)))
    else $error("read pointer did not advance");
  a_half_wrap: assert property (rd.ready && ptr[SE_HALF_W-1:0] == 16'hffff
                                |=> ptr[SE_HALF_W-1:0] == 16'h0000
                                && ptr[SE_ADDR_W-1] == $past(ptr[SE_ADDR_W-1]))
    else $error("read pointer left its half");
  a_nack_release: assert property (host_nack |=> st == S_WAIT ##1 sda_oe_n)
    else $error("line not released after nack");
  a_chip_miss: assert property (byte_done && st == S_CTRL && !addr_hit
                                |=> st == S_WAIT && sda_oe_n)
    else $error("foreign chip select answered");
endmodule

// >>> sim/se_host.sv
// Two-wire bus host model: drives scl and an open-drain data level, 20 clk_sys per bit.
// Assumes the bench ANDs sda_drv with the device's pull-down to form the wire.
module se_host (
  input wire logic clk_sys,
  input wire logic sda_wire,
  output logic scl,
  output logic sda_drv
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // With scl low this is a repeated Start; from idle the first steps change nothing.
  task automatic start();
    sda_drv <= 1'b1;
    wt(5);
    scl <= 1'b1;
    wt(5);
    sda_drv <= 1'b0;
    wt(5);
    scl <= 1'b0;
  endtask
  // Scl then stands high until the next frame.
  task automatic stop();
    wt(5);
    sda_drv <= 1'b0;
    wt(5);
    scl <= 1'b1;
    wt(5);
    sda_drv <= 1'b1;
    wt(10);
  endtask
  // Data changes only mid-low, and the wire is sampled just before scl falls.
  task automatic bit_io(input logic b, output logic s);
    wt(5);
    sda_drv <= b;
    wt(5);
    scl <= 1'b1;
    wt(9);
    s = sda_wire;
    wt(1);
    scl <= 1'b0;
  endtask
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], s);
    end
    bit_io(1'b1, s);
    ack = ~s;
  endtask
  task automatic rbyte(input logic ack_in, output logic [7:0] b, output logic rel);
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, b[i]);
    end
    bit_io(~ack_in, rel);
  endtask
  task automatic poll(input logic [7:0] c, output int tries);
    logic ack;
    tries = 0;
    ack = 1'b0;
    while (!ack && tries < 20) begin
      start();
      wbyte(c, ack);
      tries++;
    end
    stop();
  endtask
endmodule

// >>> sim/tb.sv
// Self-checking bench of the EEPROM client: page writes, protect, polling and reads.
// Assumes the design's filter latency and PROG_CYC cut down to 400 cycles.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import se_pkg::*;
  logic clk_sys, sys_rst, write_protect, chip_select_hi, chip_select_lo;
  logic sda_out, sda_oe_n, prog_busy, scl, sda_drv, ack;
  logic [SE_ADDR_W-1:0] addr_ptr, cur, page;
  logic [7:0] mem [int];
  int n_mismatch = 0;
  int n_checks = 0;
  wire sda_wire = sda_drv & (sda_oe_n | sda_out);
  se_host u_host (.clk_sys(clk_sys), .sda_wire(sda_wire), .scl(scl), .sda_drv(sda_drv));
  se_eeprom #(.PROG_CYC(400)) u_se_eeprom (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .write_protect(write_protect), .chip_select_hi(chip_select_hi),
    .chip_select_lo(chip_select_lo), .prog_busy(prog_busy), .addr_ptr(addr_ptr));
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic chk(input string nm, input logic [16:0] e, input logic [16:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic logic [7:0] cb(input logic h, input logic rw);
    return {SE_TYPE_CODE, h, chip_select_hi, chip_select_lo, rw};
  endfunction
  function automatic logic [16:0] pg(input logic [16:0] a, input int i);
    return {a[16:7], a[6:0] + i[6:0]};
  endfunction
  function automatic logic [16:0] nx(input logic [16:0] a, input int i);
    return {a[16], a[15:0] + i[15:0]};
  endfunction
  task automatic wr(input logic [16:0] a, input int n, input logic busy);
    logic k;
    logic [7:0] d;
    logic [7:0] tmp [int];
    u_host.start();
    u_host.wbyte(cb(a[16], 1'b0), k);
    chk("ctrl ack", 17'h1, {16'h0, k});
    u_host.wbyte(a[15:8], k);
    u_host.wbyte(a[7:0], k);
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      u_host.wbyte(d, k);
      chk("data ack", 17'h1, {16'h0, k});
      tmp[pg(a, i)] = d;
    end
    u_host.stop();
    // The pointer keeps stepping inside the page, so a current read follows the last byte.
    cur = pg(a, n);
    if (write_protect === 1'b0) foreach (tmp[j]) mem[j] = tmp[j];
    repeat (2) @(posedge clk_sys);
    chk("prog_busy", {16'h0, busy}, {16'h0, prog_busy});
  endtask
  task automatic pl(input logic h, input logic busy);
    int t;
    u_host.poll(cb(h, 1'b0), t);
    chk("poll refused", {16'h0, busy}, {16'h0, t > 1});
    chk("poll acked", 17'h1, {16'h0, t < 20});
  endtask
  task automatic rd(input logic [16:0] a, input int n, input logic rnd);
    logic k, rel;
    logic [7:0] d;
    logic [16:0] x;
    if (rnd) begin
      u_host.start();
      u_host.wbyte(cb(a[16], 1'b0), k);
      u_host.wbyte(a[15:8], k);
      u_host.wbyte(a[7:0], k);
    end else a = cur;
    u_host.start();
    u_host.wbyte(cb(a[16], 1'b1), k);
    chk("read ack", 17'h1, {16'h0, k});
    for (int i = 0; i < n; i++) begin
      x = nx(a, i);
      u_host.rbyte(i < n - 1, d, rel);
      if (mem.exists(x)) chk("read data", {9'h0, mem[x]}, {9'h0, d});
    end
    chk("data released", 17'h1, {16'h0, rel});
    u_host.stop();
    cur = nx(a, n);
    chk("addr_ptr", cur, addr_ptr);
    chk("sda_oe_n", 17'h1, {16'h0, sda_oe_n});
  endtask
  task automatic results();
    if (n_mismatch == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // About 60000 cycles are needed; the margin covers slow polling.
  initial begin
    repeat (90000) @(posedge clk_sys);
    n_mismatch++;
    results();
  end
  initial begin
    sys_rst = 1'b1;
    write_protect = 1'b0;
    void'($urandom(32'h3b28));
    chip_select_hi = 1'($urandom);
    chip_select_lo = 1'($urandom);
    repeat (16) @(posedge clk_sys);
    chk("reset addr_ptr", 17'h0, addr_ptr);
    chk("reset prog_busy", 17'h0, {16'h0, prog_busy});
    sys_rst <= 1'b0;
    repeat (8) @(posedge clk_sys);
    for (int i = 0; i < 3; i++) begin
      u_host.start();
      case (i)
        0: u_host.wbyte({4'h5, 1'b0, chip_select_hi, chip_select_lo, 1'b0}, ack);
        1: u_host.wbyte({SE_TYPE_CODE, 1'b0, ~chip_select_hi, chip_select_lo, 1'b0}, ack);
        default: u_host.wbyte({SE_TYPE_CODE, 1'b1, chip_select_hi, ~chip_select_lo, 1'b1}, ack);
      endcase
      chk("foreign ack", 17'h0, {16'h0, ack});
      u_host.stop();
    end
    // The last page of a half, so reading it whole also wraps the pointer.
    page = {1'($urandom), 9'h1ff, 7'h00};
    wr(page | 17'h7f, 129, 1'b1);
    pl(page[16], 1'b1);
    rd(page, 128, 1'b1);
    rd(page | 17'h05, 1, 1'b1);
    rd(17'h0, 1, 1'b0);
    wr(page | 17'h01, 2, 1'b1);
    write_protect <= 1'b1;
    pl(page[16], 1'b1);
    wr(page, 1, 1'b0);
    pl(page[16], 1'b0);
    write_protect <= 1'b0;
    // Releasing write protect must let the next write program again.
    wr(page, 1, 1'b1);
    pl(page[16], 1'b1);
    rd(17'h0, 1, 1'b0);
    rd(page, 3, 1'b1);
    for (int h = 0; h < 2; h++) begin
      rd({h[0], 16'hffff}, 2, 1'b1);
    end
    results();
  end
endmodule
